// *** src/fpg_gate.sv ***
/*
 * flash protection gate: latches option bytes after reset, decodes the
 * protection level and page locks, rules on every flash request, runs the
 * automatic main erase on a drop to the unprotected level.
 * assumes option words, requests, boot and debug inputs come from logic on
 * REF_CLK, and an axi4-lite master on the register side.
 */
// Contract
// - pages 0..31 write-locked in pairs, one lock bit per pair
// - changed lock settings act only after reset reloads them
// - program or erase of locked page refused, protection error flag set
// - boot program memory block never programmed or erased
// - system configuration block never programmed or erased
// - software relocks option block; only correct key pair unlocks it
// - level L0 only for A5/5A primary bytes and no L2 match
// - level L2 whenever secondary bytes are CC/33
// - every other read-lock combination, erased included, is L1
// - at L0 main reads free, main writes limited only by page locks
// - at L1 main reads only for main-boot code outside debug
// - at L1 code from main flash may program all unlocked pages
// - at L1 debug or sram boot blocks page writes, mass erase allowed
// - at L1 sram code, dma from sram and debug paths blocked
// - writing A5 at L1 mass-erases main then rewrites A5 internally
// - option block erase alone never starts automatic main erase
// - L2 as L1 plus debug disabled and level frozen
// - at L0 system memory reachable only when booted there
// - main mass erase accepted in every boot mode at L0/L1
// - level changes L0 to L1/L2, L1 to L0/L2 accepted
// - low lock byte bit n covers pages 2n and 2n+1
// - option byte failing complement check raises error, forced to FF
`timescale 1ns/100ps
module fpg_gate (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // option words read from the array
    input wire logic [31:0] OB_WORD_RL,
    input wire logic [31:0] OB_WORD_LOCK,
    input wire logic [31:0] OB_WORD_RL2,
    // access request
    input wire logic REQ_VALID,
    input wire logic [1:0] REQ_AREA,
    input wire logic [1:0] REQ_OP,
    input wire logic [4:0] REQ_PAGE,
    input wire logic [3:0] REQ_OFFSET,
    input wire logic [7:0] REQ_DATA,
    input wire logic [1:0] REQ_MASTER,
    input wire logic [1:0] REQ_BOOT,
    input wire logic REQ_DEBUG,
    // access answer
    output logic REQ_GRANT,
    output logic REQ_REFUSE,
    // automatic erase handshake with the array
    output logic MASS_ERASE_GO,
    input wire logic MASS_ERASE_DONE,
    output logic RL_REWRITE_GO,
    // protection state
    output logic [1:0] LEVEL,
    output logic [15:0] PAGE_LOCK,
    output logic DEBUG_OFF,
    // axi4-lite slave
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        fpg_pkg::fpg_state_t st;
        logic [7:0] rl1;
        logic [7:0] rl1c;
        logic [7:0] rl2;
        logic [7:0] rl2c;
        logic [15:0] lock;
        logic ob_err;
        fpg_pkg::fpg_level_t level;
        logic dbg_off;
        logic optwe;
        logic key1_ok;
        logic key_locked;
        logic prot_err;
        logic grant;
        logic refuse;
        logic me_go;
        logic rw_go;
        logic awrdy;
        logic wrdy;
        logic aw_ok;
        logic w_ok;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arrdy;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } fpg_regs_t;

    localparam fpg_regs_t RESET_VAL = '{st: fpg_pkg::ST_LOAD, level: fpg_pkg::LVL_L1,
        rl1: fpg_pkg::BYTE_ERASED, rl1c: fpg_pkg::BYTE_ERASED, rl2: fpg_pkg::BYTE_ERASED,
        rl2c: fpg_pkg::BYTE_ERASED, lock: '0, awrdy: 1'b1, wrdy: 1'b1, arrdy: 1'b1,
        awaddr: '0, wdata: '0, wstrb: '0, bresp: '0, rdata: '0, rresp: '0, default: 1'b0};

    fpg_regs_t q;
    fpg_regs_t d;

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    // complement check: erased pair skips it, a mismatch forces FF
    function automatic logic [8:0] fpg_check(input logic [7:0] b, input logic [7:0] c);
        logic bad;
        bad = (b != ~c) && !(b == fpg_pkg::BYTE_ERASED && c == fpg_pkg::BYTE_ERASED);
        return bad ? {1'b1, fpg_pkg::BYTE_ERASED} : {1'b0, b};
    endfunction

    // level decode from the checked read-lock bytes
    function automatic fpg_pkg::fpg_level_t fpg_decode(input logic [7:0] r1, input logic [7:0] r1c,
        input logic [7:0] r2, input logic [7:0] r2c);
        fpg_pkg::fpg_level_t lv;
        lv = fpg_pkg::LVL_L1;
        if (r2 == fpg_pkg::RL_L2_BYTE && r2c == fpg_pkg::RL_L2_COMP) begin
            lv = fpg_pkg::LVL_L2;
        end else if (r1 == fpg_pkg::RL_L0_BYTE && r1c == fpg_pkg::RL_L0_COMP) begin
            lv = fpg_pkg::LVL_L0;
        end
        return lv;
    endfunction

    // single permit for one request
    function automatic logic fpg_permit(input fpg_pkg::fpg_level_t lv, input fpg_pkg::fpg_area_t ar,
        input fpg_pkg::fpg_op_t op, input fpg_pkg::fpg_master_t m, input fpg_pkg::fpg_boot_t bt,
        input logic dbg, input logic lk, input logic optwe);
        logic prot;
        logic trusted;
        logic modify;
        logic ok;
        prot = (lv != fpg_pkg::LVL_L0);
        trusted = (m != fpg_pkg::M_DEBUG) && (bt == fpg_pkg::BOOT_MAIN) && !dbg;
        modify = (op != fpg_pkg::OP_READ);
        ok = 1'b0;
        if (lv == fpg_pkg::LVL_L2 && (m == fpg_pkg::M_DEBUG || dbg)) begin
            ok = 1'b0;
        end else begin
            case (ar)
                fpg_pkg::AREA_MAIN: begin
                    if (op == fpg_pkg::OP_MASS_ERASE) begin
                        ok = 1'b1;
                    end else if (!prot) begin
                        ok = !modify || !lk;
                    end else begin
                        ok = trusted && (!modify || !lk);
                    end
                end
                fpg_pkg::AREA_OPTION: begin
                    ok = !modify || (optwe && lv != fpg_pkg::LVL_L2 && op != fpg_pkg::OP_MASS_ERASE);
                end
                fpg_pkg::AREA_SYSMEM: begin
                    ok = !modify && !prot && bt == fpg_pkg::BOOT_SYSMEM;
                end
                fpg_pkg::AREA_SYSCFG: begin
                    ok = !modify && !(prot && (m == fpg_pkg::M_DEBUG || bt == fpg_pkg::BOOT_SRAM));
                end
                default: begin
                    ok = 1'b0;
                end
            endcase
        end
        return ok;
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    logic [8:0] chk_rl1;
    logic [8:0] chk_rl2;
    logic [8:0] chk_lo;
    logic [8:0] chk_hi;
    logic req_ok;
    logic req_mod;
    logic auto_erase;

    // complement checks on the raw option words
    // byte check
    assign chk_rl1 = fpg_check(OB_WORD_RL[7:0], OB_WORD_RL[15:8]);
    assign chk_rl2 = fpg_check(OB_WORD_RL2[7:0], OB_WORD_RL2[15:8]);
    assign chk_lo = fpg_check(OB_WORD_LOCK[7:0], OB_WORD_LOCK[15:8]);
    assign chk_hi = fpg_check(OB_WORD_LOCK[23:16], OB_WORD_LOCK[31:24]);

    // request ruling against the latched state
    // single ruling
    assign req_ok = fpg_permit(q.level, fpg_pkg::fpg_area_t'(REQ_AREA), fpg_pkg::fpg_op_t'(REQ_OP),
        fpg_pkg::fpg_master_t'(REQ_MASTER), fpg_pkg::fpg_boot_t'(REQ_BOOT), REQ_DEBUG,
        q.lock[REQ_PAGE[4:1]], q.optwe) && q.st == fpg_pkg::ST_IDLE;
    assign req_mod = REQ_OP != fpg_pkg::OP_READ;
    assign auto_erase = REQ_VALID && req_ok && REQ_AREA == fpg_pkg::AREA_OPTION
        && REQ_OP == fpg_pkg::OP_PROG && REQ_OFFSET == fpg_pkg::OB_RL_OFFSET
        && REQ_DATA == fpg_pkg::RL_L0_BYTE && q.level == fpg_pkg::LVL_L1;

    always_comb begin
        d = q;
        d.grant = 1'b0;
        d.refuse = 1'b0;
        d.me_go = 1'b0;
        d.rw_go = 1'b0;
        // protection sequencer
        case (q.st)
            fpg_pkg::ST_LOAD: begin
                d.rl1 = chk_rl1[7:0];
                d.rl1c = OB_WORD_RL[15:8];
                d.rl2 = chk_rl2[7:0];
                d.rl2c = OB_WORD_RL2[15:8];
                d.ob_err = chk_rl1[8] | chk_rl2[8] | chk_lo[8] | chk_hi[8];
                d.lock = ~{chk_hi[7:0], chk_lo[7:0]};
                d.level = fpg_decode(chk_rl1[7:0], OB_WORD_RL[15:8], chk_rl2[7:0], OB_WORD_RL2[15:8]);
                d.dbg_off = fpg_decode(chk_rl1[7:0], OB_WORD_RL[15:8], chk_rl2[7:0],
                    OB_WORD_RL2[15:8]) == fpg_pkg::LVL_L2;
                d.st = fpg_pkg::ST_IDLE;
            end
            fpg_pkg::ST_IDLE: begin
                if (auto_erase) begin
                    d.me_go = 1'b1;
                    d.st = fpg_pkg::ST_ERASE_WAIT;
                end
            end
            fpg_pkg::ST_ERASE_WAIT: begin
                if (MASS_ERASE_DONE) begin
                    d.rw_go = 1'b1;
                    d.st = fpg_pkg::ST_REWRITE;
                end
            end
            fpg_pkg::ST_REWRITE: begin
                d.st = fpg_pkg::ST_IDLE; // level stays until the next reset
            end
            default: begin
                d.st = fpg_pkg::ST_IDLE;
            end
        endcase

        // axi write channel capture
        if (S_AXI_AWVALID && q.awrdy) begin
            d.awaddr = S_AXI_AWADDR;
            d.awrdy = 1'b0;
            d.aw_ok = 1'b1;
        end
        if (S_AXI_WVALID && q.wrdy) begin
            d.wdata = S_AXI_WDATA;
            d.wstrb = S_AXI_WSTRB;
            d.wrdy = 1'b0;
            d.w_ok = 1'b1;
        end
        // axi write effect once both halves are held
        if (q.aw_ok && q.w_ok && !q.bvalid) begin
            d.bvalid = 1'b1;
            d.bresp = fpg_pkg::RESP_OKAY;
            case (q.awaddr)
                fpg_pkg::REG_CTRL: begin
                    if (q.wstrb[0] && !q.wdata[fpg_pkg::CTRL_OPTWE_BIT]) begin
                        d.optwe = 1'b0;
                    end
                end
                fpg_pkg::REG_KEY: begin
                    if (q.key_locked || q.wstrb != fpg_pkg::STRB_ALL) begin
                        d.bresp = fpg_pkg::RESP_SLVERR;
                    end else if (!q.key1_ok && q.wdata == fpg_pkg::OPT_KEY1) begin
                        d.key1_ok = 1'b1;
                    end else if (q.key1_ok && q.wdata == fpg_pkg::OPT_KEY2) begin
                        d.key1_ok = 1'b0;
                        d.optwe = 1'b1;
                    end else begin
                        d.key1_ok = 1'b0;
                        d.key_locked = 1'b1;
                        d.optwe = 1'b0;
                        d.bresp = fpg_pkg::RESP_SLVERR;
                    end
                end
                fpg_pkg::REG_STATUS: begin
                    if (q.wstrb[0] && q.wdata[fpg_pkg::STS_PROT_ERR_BIT]) begin
                        d.prot_err = 1'b0;
                    end
                end
                fpg_pkg::REG_OPTION, fpg_pkg::REG_PAGE_LOCK, fpg_pkg::REG_READLOCK: begin
                    d.bresp = fpg_pkg::RESP_OKAY; // read-only, write ignored
                end
                default: begin
                    d.bresp = fpg_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (q.bvalid && S_AXI_BREADY) begin
            d.bvalid = 1'b0;
            d.aw_ok = 1'b0;
            d.w_ok = 1'b0;
            d.awrdy = 1'b1;
            d.wrdy = 1'b1;
        end

        // axi read channel
        if (S_AXI_ARVALID && q.arrdy) begin
            d.arrdy = 1'b0;
            d.rvalid = 1'b1;
            d.rresp = fpg_pkg::RESP_OKAY;
            d.rdata = '0;
            case (S_AXI_ARADDR)
                fpg_pkg::REG_CTRL: d.rdata[fpg_pkg::CTRL_OPTWE_BIT] = q.optwe;
                fpg_pkg::REG_KEY: d.rdata = '0;
                fpg_pkg::REG_STATUS: begin
                    d.rdata[fpg_pkg::STS_PROT_ERR_BIT] = q.prot_err;
                    d.rdata[fpg_pkg::STS_BUSY_BIT] = q.st != fpg_pkg::ST_IDLE;
                    d.rdata[fpg_pkg::STS_KEY_LOCK_BIT] = q.key_locked;
                end
                fpg_pkg::REG_OPTION: begin
                    d.rdata[fpg_pkg::OPT_ERR_BIT] = q.ob_err;
                    d.rdata[fpg_pkg::OPT_LEVEL_LSB +: 2] = q.level;
                    d.rdata[fpg_pkg::OPT_DBG_OFF_BIT] = q.dbg_off;
                end
                fpg_pkg::REG_PAGE_LOCK: d.rdata[15:0] = q.lock;
                fpg_pkg::REG_READLOCK: d.rdata = {q.rl2c, q.rl2, q.rl1c, q.rl1};
                default: d.rresp = fpg_pkg::RESP_SLVERR;
            endcase
        end
        if (q.rvalid && S_AXI_RREADY) begin
            d.rvalid = 1'b0;
            d.arrdy = 1'b1;
        end

        // request answer, one cycle after the request
        // refuse and flag
        if (REQ_VALID) begin
            d.grant = req_ok;
            d.refuse = !req_ok;
            if (!req_ok && req_mod && q.st == fpg_pkg::ST_IDLE) begin
                d.prot_err = 1'b1; // set wins over a same-cycle clear
            end
        end
    end

    // state register
    // held after load
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            q <= RESET_VAL;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign REQ_GRANT = q.grant;
    assign REQ_REFUSE = q.refuse;
    assign MASS_ERASE_GO = q.me_go;
    assign RL_REWRITE_GO = q.rw_go;
    assign LEVEL = q.level;
    assign PAGE_LOCK = q.lock;
    assign DEBUG_OFF = q.dbg_off;
    assign S_AXI_AWREADY = q.awrdy;
    assign S_AXI_WREADY = q.wrdy;
    assign S_AXI_BRESP = q.bresp;
    assign S_AXI_BVALID = q.bvalid;
    assign S_AXI_ARREADY = q.arrdy;
    assign S_AXI_RDATA = q.rdata;
    assign S_AXI_RRESP = q.rresp;
    assign S_AXI_RVALID = q.rvalid;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking fpg_cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_N);

    locked_page_refuse_a: assert property (
        REQ_VALID && REQ_AREA == fpg_pkg::AREA_MAIN && REQ_OP == fpg_pkg::OP_PROG
        && q.lock[REQ_PAGE[4:1]] && q.st == fpg_pkg::ST_IDLE |=> REQ_REFUSE && q.prot_err)
        else $error("locked page program not refused");
    sysmem_no_write_a: assert property (
        REQ_VALID && REQ_AREA == fpg_pkg::AREA_SYSMEM && REQ_OP != fpg_pkg::OP_READ |=> !REQ_GRANT)
        else $error("system memory write granted");
    syscfg_no_write_a: assert property (
        REQ_VALID && REQ_AREA == fpg_pkg::AREA_SYSCFG && REQ_OP != fpg_pkg::OP_READ |=> !REQ_GRANT)
        else $error("configuration block write granted");
    unlock_by_key_a: assert property (
        $rose(q.optwe) |-> $past(q.key1_ok) && !q.key_locked)
        else $error("option unlock without key pair");
    level_l2_decode_a: assert property (
        q.st != fpg_pkg::ST_LOAD && q.rl2 == fpg_pkg::RL_L2_BYTE && q.rl2c == fpg_pkg::RL_L2_COMP
        |-> LEVEL == fpg_pkg::LVL_L2 && DEBUG_OFF)
        else $error("L2 encoding not decoded");
    level_l0_decode_a: assert property (
        q.st != fpg_pkg::ST_LOAD && LEVEL == fpg_pkg::LVL_L0 |-> q.rl1 == fpg_pkg::RL_L0_BYTE
        && q.rl1c == fpg_pkg::RL_L0_COMP && !(q.rl2 == fpg_pkg::RL_L2_BYTE && q.rl2c == fpg_pkg::RL_L2_COMP))
        else $error("L0 decoded from wrong bytes");
    l1_debug_read_a: assert property (
        REQ_VALID && REQ_AREA == fpg_pkg::AREA_MAIN && LEVEL != fpg_pkg::LVL_L0
        && REQ_OP != fpg_pkg::OP_MASS_ERASE && (REQ_MASTER == fpg_pkg::M_DEBUG || REQ_DEBUG) |=> REQ_REFUSE)
        else $error("protected main read granted to debug");
    mass_erase_ok_a: assert property (
        REQ_VALID && REQ_AREA == fpg_pkg::AREA_MAIN && REQ_OP == fpg_pkg::OP_MASS_ERASE
        && LEVEL != fpg_pkg::LVL_L2 && q.st == fpg_pkg::ST_IDLE |=> REQ_GRANT)
        else $error("mass erase refused");
    auto_erase_seq_a: assert property (
        MASS_ERASE_GO |-> q.st == fpg_pkg::ST_ERASE_WAIT && !RL_REWRITE_GO)
        else $error("read-lock rewrite out of order");
    erase_done_rewrite_a: assert property (
        q.st == fpg_pkg::ST_ERASE_WAIT && MASS_ERASE_DONE |=> RL_REWRITE_GO && q.st == fpg_pkg::ST_REWRITE)
        else $error("read-lock rewrite missing after erase");
    level_held_a: assert property (
        q.st != fpg_pkg::ST_LOAD && $past(q.st) != fpg_pkg::ST_LOAD |-> $stable(LEVEL) && $stable(PAGE_LOCK))
        else $error("protection state changed after load");
endmodule // fpg_gate

// *** src/fpg_pkg.sv ***
/*
 * shared constants and types of the flash protection gate:
 * register map, option byte encodings, access enumerations.
 * assumes a 32-bit axi4-lite register bus and one system clock.
 */
package fpg_pkg;
    // ----------------------------------------------------------------
    // register map (byte addresses) and field positions
    // ----------------------------------------------------------------
    localparam int AXI_AW = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_KEY = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_OPTION = 8'h0C;
    localparam logic [7:0] REG_PAGE_LOCK = 8'h10;
    localparam logic [7:0] REG_READLOCK = 8'h14;
    localparam int CTRL_OPTWE_BIT = 0;
    localparam int STS_PROT_ERR_BIT = 0;
    localparam int STS_BUSY_BIT = 1;
    localparam int STS_KEY_LOCK_BIT = 2;
    localparam int OPT_ERR_BIT = 0;
    localparam int OPT_LEVEL_LSB = 1;
    localparam int OPT_DBG_OFF_BIT = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [3:0] STRB_ALL = 4'hF;
    // ----------------------------------------------------------------
    // option byte encodings and unlock keys
    // ----------------------------------------------------------------
    localparam logic [31:0] OPT_KEY1 = 32'h45670123;
    localparam logic [31:0] OPT_KEY2 = 32'hCDEF89AB;
    localparam logic [7:0] BYTE_ERASED = 8'hFF;
    localparam logic [7:0] RL_L0_BYTE = 8'hA5;
    localparam logic [7:0] RL_L0_COMP = 8'h5A;
    localparam logic [7:0] RL_L2_BYTE = 8'hCC;
    localparam logic [7:0] RL_L2_COMP = 8'h33;
    localparam logic [3:0] OB_RL_OFFSET = 4'h0;
    localparam int PAGES = 32;
    localparam int PAGES_PER_UNIT = 2;
    localparam int LOCK_UNITS = PAGES / PAGES_PER_UNIT;
    // ----------------------------------------------------------------
    // enumerations
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {LVL_L0 = 2'b00, LVL_L1 = 2'b01, LVL_L2 = 2'b10} fpg_level_t;
    typedef enum logic [1:0] {AREA_MAIN = 2'b00, AREA_OPTION = 2'b01, AREA_SYSMEM = 2'b10,
        AREA_SYSCFG = 2'b11} fpg_area_t;
    typedef enum logic [1:0] {OP_READ = 2'b00, OP_PROG = 2'b01, OP_PAGE_ERASE = 2'b10,
        OP_MASS_ERASE = 2'b11} fpg_op_t;
    typedef enum logic [1:0] {M_CPU = 2'b00, M_DMA = 2'b01, M_DEBUG = 2'b10} fpg_master_t;
    typedef enum logic [1:0] {BOOT_MAIN = 2'b00, BOOT_SYSMEM = 2'b01, BOOT_SRAM = 2'b10} fpg_boot_t;
    typedef enum logic [1:0] {ST_LOAD = 2'b00, ST_IDLE = 2'b01, ST_ERASE_WAIT = 2'b10,
        ST_REWRITE = 2'b11} fpg_state_t;
endpackage

// *** tb/flash_protection_gate_test.sv ***
/*
 * bench: request table per protection level, then key unlock and level drop.
 * assumes the gate's registered one-cycle answers and axi4-lite slave.
 */
`timescale 1ns/100ps
module flash_protection_gate_test;
    typedef struct {logic [1:0] ph, ar, op; logic [4:0] pg; logic [1:0] m, b; logic d, g;} fpgt_row_t;
    logic clk, rst_n, vld, dbg, awv, wv, brd, arv, rrd, grant, refuse, mgo, mdone, rwgo, doff;
    logic awr, wr, bv, arr, rv;
    logic [1:0] area, op, mst, boot, level, bresp, rresp, resp;
    logic [4:0] page;
    logic [3:0] offs, ws;
    logic [7:0] data, awa, ara;
    logic [15:0] plock;
    logic [31:0] ob_rl, ob_lk, ob_rl2, wd, rdata, rd;
    int fail_count = 0, total_checks = 0;
    fpgt_row_t rows [15] = '{
        '{2'h0, 2'h0, 2'h1, 5'h01, 2'h0, 2'h0, 1'h0, 1'h0}, // locked pair
        '{2'h0, 2'h0, 2'h1, 5'h02, 2'h0, 2'h0, 1'h0, 1'h1}, // next pair free
        '{2'h0, 2'h0, 2'h0, 5'h00, 2'h2, 2'h2, 1'h1, 1'h1}, // free read
        '{2'h0, 2'h2, 2'h0, 5'h00, 2'h0, 2'h1, 1'h0, 1'h1}, // sysmem boot
        '{2'h0, 2'h2, 2'h0, 5'h00, 2'h0, 2'h0, 1'h0, 1'h0}, // other boot
        '{2'h0, 2'h2, 2'h1, 5'h00, 2'h0, 2'h1, 1'h0, 1'h0}, // boot program fixed
        '{2'h0, 2'h3, 2'h2, 5'h00, 2'h0, 2'h1, 1'h0, 1'h0}, // config fixed
        '{2'h0, 2'h0, 2'h3, 5'h00, 2'h2, 2'h2, 1'h1, 1'h1}, // mass erase
        '{2'h1, 2'h0, 2'h0, 5'h00, 2'h0, 2'h0, 1'h0, 1'h1}, // trusted read
        '{2'h1, 2'h0, 2'h0, 5'h00, 2'h0, 2'h0, 1'h1, 1'h0}, // debug mode
        '{2'h1, 2'h0, 2'h1, 5'h1E, 2'h0, 2'h0, 1'h0, 1'h1}, // iap program
        '{2'h1, 2'h0, 2'h2, 5'h04, 2'h0, 2'h2, 1'h0, 1'h0}, // sram page erase
        '{2'h1, 2'h0, 2'h3, 5'h00, 2'h0, 2'h2, 1'h0, 1'h1}, // mass erase
        '{2'h1, 2'h0, 2'h0, 5'h00, 2'h1, 2'h2, 1'h0, 1'h0}, // dma from sram
        '{2'h2, 2'h0, 2'h0, 5'h00, 2'h2, 2'h0, 1'h0, 1'h0}}; // debug port
    fpg_gate i_fpg_gate (.REF_CLK(clk), .RST_N(rst_n), .OB_WORD_RL(ob_rl), .OB_WORD_LOCK(ob_lk),
        .OB_WORD_RL2(ob_rl2), .REQ_VALID(vld), .REQ_AREA(area), .REQ_OP(op), .REQ_PAGE(page),
        .REQ_OFFSET(offs), .REQ_DATA(data), .REQ_MASTER(mst), .REQ_BOOT(boot), .REQ_DEBUG(dbg),
        .REQ_GRANT(grant), .REQ_REFUSE(refuse), .MASS_ERASE_GO(mgo), .MASS_ERASE_DONE(mdone),
        .RL_REWRITE_GO(rwgo), .LEVEL(level), .PAGE_LOCK(plock), .DEBUG_OFF(doff),
        .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
        .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bv), .S_AXI_BREADY(brd), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
        .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
        .S_AXI_RREADY(rrd));
    fpg_array_model i_fpg_array_model (.clk(clk), .rst_n(rst_n), .go(mgo), .done(mdone));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic conclude();
        $display("checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic boot_up(input logic [31:0] rl, input logic [31:0] rl2);
        ob_rl <= rl;
        ob_rl2 <= rl2;
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask
    // one request, answer sampled in the cycle after the taking edge
    task automatic req(input fpgt_row_t r);
        @(posedge clk);
        {vld, area, op, page, mst, boot, dbg} <= {1'b1, r.ar, r.op, r.pg, r.m, r.b, r.d};
        @(posedge clk);
        vld <= 1'b0;
        #1;
        chk("answer", {r.g, !r.g}, {grant, refuse});
    endtask
    task automatic wait_edge(input int n);
        if (n > 40) begin
            fail_count++;
            conclude();
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        {awv, wv, brd, awa, wd} <= {3'h7, a, d};
        for (n = 0; n <= 40; n++) begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
            if (bv) break;
        end
        wait_edge(n);
        resp = bresp;
        brd <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a);
        int n;
        @(posedge clk);
        {arv, rrd, ara} <= {2'h3, a};
        for (n = 0; n <= 40; n++) begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
            if (rv) break;
        end
        wait_edge(n);
        {resp, rd} = {rresp, rdata};
        rrd <= 1'b0;
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        int n;
        {vld, dbg, awv, wv, brd, arv, rrd, area, op, mst, boot, page, offs, data} = '0;
        {awa, ara, wd, ws, rst_n} = {48'h0, fpg_pkg::STRB_ALL, 1'b0};
        ob_lk = 32'h00FF01FE; // unit 0 locked
        for (int ph = 0; ph < 3; ph++) begin
            boot_up(ph == 0 ? 32'h00005AA5 : 32'hFFFFFFFF, ph == 2 ? 32'h000033CC : 32'h0000FFFF);
            chk("level", ph, level);
            chk("page lock", 32'h1, plock);
            chk("debug off", ph == 2, doff);
            foreach (rows[i]) if (rows[i].ph == ph) req(rows[i]);
        end
        boot_up(32'hFFFFFFFF, 32'h0000FFFF);
        axw(fpg_pkg::REG_KEY, fpg_pkg::OPT_KEY1);
        axw(fpg_pkg::REG_KEY, fpg_pkg::OPT_KEY2);
        chk("key resp", fpg_pkg::RESP_OKAY, resp);
        req('{2'h1, 2'h1, 2'h2, 5'h00, 2'h0, 2'h0, 1'h0, 1'h1}); // option erase
        chk("no auto erase", 1'b0, mgo);
        @(posedge clk);
        data <= fpg_pkg::RL_L0_BYTE;
        req('{2'h1, 2'h1, 2'h1, 5'h00, 2'h0, 2'h0, 1'h0, 1'h1}); // write A5
        chk("auto erase", 1'b1, mgo);
        for (n = 0; n <= 40 && rwgo !== 1'b1; n++) @(posedge clk);
        wait_edge(n);
        chk("level kept", 32'h1, level);
        axw(fpg_pkg::REG_CTRL, 32'h0);
        req('{2'h1, 2'h1, 2'h1, 5'h00, 2'h0, 2'h0, 1'h0, 1'h0}); // relocked
        axr(fpg_pkg::REG_STATUS);
        chk("prot err", 32'h1, rd[0]);
        axr(8'hFC);
        chk("unmapped", fpg_pkg::RESP_SLVERR, resp);
        boot_up(32'h00001234, 32'h0000FFFF); // primary byte fails its complement
        axr(fpg_pkg::REG_OPTION);
        chk("option err", 32'h3, rd);
        axr(fpg_pkg::REG_READLOCK);
        chk("forced byte", 32'hFFFF12FF, rd);
        conclude();
    end
endmodule // flash_protection_gate_test

// *** tb/fpg_array_model.sv ***
/*
 * flash array stand-in: answers the automatic main erase.
 * assumes go and done are single-cycle pulses on the system clock.
 */
`timescale 1ns/100ps
module fpg_array_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // erase handshake
    input wire logic go,
    output logic done
);
    logic [3:0] cnt_q;
    always_ff @(posedge clk) begin
        done <= 1'b0;
        if (!rst_n) cnt_q <= 4'h0;
        else if (go) cnt_q <= 4'h5; // erase takes a few cycles
        else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
            done <= (cnt_q == 4'h1);
        end
    end
endmodule // fpg_array_model
